//--- pcm_pkt_assertions.sv
// protocol checker for the telemetry stream packetizer
`timescale 1ns/1ps
`default_nettype none
module pcm_pkt_checker
  import pcm_pkt_pkg::*;
(
  input wire logic                   ref_clk_in,
  input wire logic                   rst_in,
  input wire logic [4:0]             avs_address_in,
  input wire logic                   avs_read_in,
  input wire logic                   avs_write_in,
  input wire logic [31:0]            avs_writedata_in,
  input wire logic [3:0]             avs_byteenable_in,
  input wire logic [31:0]            avs_readdata_out,
  input wire logic                   avs_waitrequest_out,
  input wire logic                   bit_valid_in,
  input wire logic                   frame_first_in,
  input wire pcm_pkt_pkg::out_word_t word_out,
  input wire logic [1:0]             time_fmt_out,
  input wire logic                   irq_out
);
  import pcm_pkt_pkg::*;
  // ==========
  // mirror of mode and format, so the header checks arm in every mode except throughput
  logic [3:0] ctrl_q;
  logic [1:0] fmt_q;
  logic       wdone;
  assign wdone = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl_q <= CTRL_RST;
      fmt_q  <= 2'h0;
    end else if (wdone && avs_address_in == CTRL_OFS) begin
      ctrl_q <= avs_writedata_in[3:0];
    end else if (wdone && avs_address_in == FLAGS_OFS) begin
      fmt_q <= avs_writedata_in[3:2];
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence hdr_go;
    bit_valid_in && frame_first_in && ctrl_q[EN_BIT] && ctrl_q[1:0] != MODE_THRU;
  endsequence
  sequence tag_words;
    word_out.valid [*4];
  endsequence
  // ==========
  wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  wait_answer_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("request not answered");
  idle_reset_a: assert property (disable iff (1'b0) rst_in |=> avs_waitrequest_out
    && !word_out.valid && !irq_out && time_fmt_out == 2'h0) else $error("bad reset state");
  unmapped_zero_a: assert property (avs_read_in && !avs_waitrequest_out
    && avs_address_in > FCNT_OFS |-> avs_readdata_out == 32'h0) else $error("unmapped read");
  fmt_copy_a: assert property (wdone && avs_address_in == FLAGS_OFS |=> ##1
    time_fmt_out == fmt_q) else $error("format copy wrong");
  hdr_sixteen_a: assert property (hdr_go ##0 !ctrl_q[ALIGN_BIT] |-> ##[1:3]
    tag_words ##1 (word_out.valid && word_out.data[15] && word_out.data[13:12] != 2'h1
    && word_out.data[11:0] == 12'h000)) else $error("short header wrong");
  hdr_wide_a: assert property (hdr_go ##0 ctrl_q[ALIGN_BIT] |-> ##[1:3] tag_words
    ##1 word_out.valid ##1 (word_out.valid && word_out.data == 16'h0000))
    else $error("wide header wrong");
  irq_mask_a: assert property (wdone && avs_address_in == IEN_OFS
    && avs_writedata_in[2:0] == 3'h0 |-> ##2 !irq_out [*3]) else $error("masked irq high");
endmodule : pcm_pkt_checker
bind pcm_stream_packetizer pcm_pkt_checker i_chk (.ref_clk_in, .rst_in, .avs_address_in,
  .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
  .avs_waitrequest_out, .bit_valid_in, .frame_first_in, .word_out, .time_fmt_out, .irq_out);
`default_nettype wire

//--- pcm_pkt_pkg.sv
// shared constants and types for the telemetry stream packetizer
package pcm_pkt_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [4:0] CTRL_OFS    = 5'h00;
  localparam logic [4:0] FLAGS_OFS   = 5'h04;
  localparam logic [4:0] CSDW_OFS    = 5'h08;
  localparam logic [4:0] STAT_OFS    = 5'h0C;
  localparam logic [4:0] ICLR_OFS    = 5'h10;
  localparam logic [4:0] IEN_OFS     = 5'h14;
  localparam logic [4:0] FCNT_OFS    = 5'h18;
  // ==========================================================
  // field positions and values
  localparam int          MODE_LSB   = 0;
  localparam int          ALIGN_BIT  = 2;
  localparam int          EN_BIT     = 3;
  localparam int          ABS_BIT    = 6;
  localparam int          FMT_LSB    = 2;
  localparam logic [1:0]  MODE_THRU  = 2'h0;
  localparam logic [1:0]  MODE_PACK  = 2'h1;
  localparam logic [1:0]  MODE_UNPK  = 2'h2;
  localparam int          EV_HDR     = 0;
  localparam int          EV_OVR     = 1;
  localparam int          EV_CSDW    = 2;
  localparam int          NEV        = 3;
  localparam logic [3:0]  CTRL_RST   = 4'h0;
  localparam logic [7:0]  FLAGS_RST  = 8'h00;
  localparam logic [31:0] CSDW_RST   = 32'h0000_0000;
  localparam logic [2:0]  HDR_LAST16 = 3'h4;
  localparam logic [2:0]  HDR_LAST32 = 3'h5;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_CSDW = 3'b010,
    S_HDR  = 3'b100
  } seq_state_t;
  typedef struct packed {
    logic       minor_locked;
    logic [1:0] major_code;
  } sync_lock_field_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } out_word_t;
endpackage : pcm_pkt_pkg

//--- pcm_source.sv
// far-side model: serial telemetry source with recorder time counters
`timescale 1ns/1ps
`default_nettype none
module pcm_source (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        go_in,
  input  wire logic [5:0]  len_in,
  input  wire logic [31:0] pat_in,
  output logic             bit_valid_out,
  output logic             bit_out,
  output logic             frame_first_out,
  output logic             busy_out,
  output logic [47:0]      rtc_out,
  output logic [63:0]      abs_out
);
  // ==========
  logic [5:0]  left_q;
  logic [31:0] sh_q;
  logic        ph_q;
  logic        first_q;
  assign busy_out = left_q != 6'h0;
  assign abs_out  = {rtc_out, 16'h5A5A};
  always_ff @(posedge clk_in) begin
    bit_valid_out   <= 1'b0;
    frame_first_out <= 1'b0;
    // toggles between bits so a stale value is never mistaken for data
    bit_out <= !bit_out;
    rtc_out <= rst_in ? 48'h0 : rtc_out + 48'h1_0001_0001;
    if (rst_in) begin
      left_q  <= 6'h0;
      bit_out <= 1'b0;
    end else if (go_in) begin
      {left_q, sh_q, ph_q, first_q} <= {len_in, pat_in, 2'b01};
    end else if (busy_out) begin
      ph_q <= !ph_q;
      if (!ph_q) begin
        {bit_valid_out, bit_out, frame_first_out} <= {1'b1, sh_q[31], first_q};
        first_q <= 1'b0;
        sh_q    <= {sh_q[30:0], 1'b0};
        left_q  <= left_q - 6'h1;
      end
    end
  end
endmodule : pcm_source
`default_nettype wire

//--- pcm_stream_packetizer.sv
// telemetry stream packetizer with frame prefix headers and register slave
//
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
`default_nettype none

module pcm_stream_packetizer
  import pcm_pkt_pkg::*;
(
  input  wire  logic                        ref_clk_in,
  input  wire  logic                        rst_in,
  input  wire  logic [4:0]                  avs_address_in,
  input  wire  logic                        avs_read_in,
  input  wire  logic                        avs_write_in,
  input  wire  logic [31:0]                 avs_writedata_in,
  input  wire  logic [3:0]                  avs_byteenable_in,
  output logic [31:0]                       avs_readdata_out,
  output logic                              avs_waitrequest_out,
  input  wire  logic                        pkt_start_in,
  input  wire  logic                        bit_valid_in,
  input  wire  logic                        bit_in,
  input  wire  logic                        frame_first_in,
  input  wire  pcm_pkt_pkg::sync_lock_field_t sync_lock_in,
  input  wire  logic [47:0]                 rtc_count_in,
  input  wire  logic [63:0]                 abs_time_in,
  output pcm_pkt_pkg::out_word_t            word_out,
  output logic [1:0]                        time_fmt_out,
  output logic                              irq_out
);
  import pcm_pkt_pkg::*;

  // ==========================================================
  // register file
  logic [3:0]     ctrl_q;
  logic [7:0]     flags_q;
  logic [31:0]    csdw_q;
  logic [NEV-1:0] stat_q;
  logic [NEV-1:0] ien_q;
  logic [15:0]    fcnt_q;
  logic [NEV-1:0] ev;
  logic           req;
  logic           wr_go;
  logic [31:0]    rd_d;

  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  assign req   = avs_read_in | avs_write_in;
  assign wr_go = avs_write_in & ~avs_waitrequest_out;

  // one wait cycle, then the transfer completes with waitrequest low
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      avs_waitrequest_out <= 1'b1;
    end else if (req && avs_waitrequest_out) begin
      avs_waitrequest_out <= 1'b0;
    end else begin
      avs_waitrequest_out <= 1'b1;
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (avs_address_in)
      CTRL_OFS:  rd_d[3:0]     = ctrl_q;
      FLAGS_OFS: rd_d[7:0]     = flags_q;
      CSDW_OFS:  rd_d          = csdw_q;
      STAT_OFS:  rd_d[NEV-1:0] = stat_q;
      IEN_OFS:   rd_d[NEV-1:0] = ien_q;
      FCNT_OFS:  rd_d[15:0]    = fcnt_q;
      default:   rd_d          = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      avs_readdata_out <= 32'h0000_0000;
    end else if (avs_read_in && avs_waitrequest_out) begin
      avs_readdata_out <= rd_d;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl_q  <= CTRL_RST;
      flags_q <= FLAGS_RST;
      csdw_q  <= CSDW_RST;
      ien_q   <= '0;
    end else if (wr_go) begin
      unique case (avs_address_in)
        CTRL_OFS:  ctrl_q  <= 4'(lane_merge({28'h0, ctrl_q}, avs_writedata_in,
                                            avs_byteenable_in));
        FLAGS_OFS: flags_q <= 8'(lane_merge({24'h0, flags_q}, avs_writedata_in,
                                            avs_byteenable_in));
        CSDW_OFS:  csdw_q  <= lane_merge(csdw_q, avs_writedata_in, avs_byteenable_in);
        IEN_OFS:   ien_q   <= avs_byteenable_in[0] ? avs_writedata_in[NEV-1:0] : ien_q;
        default:   ;
      endcase
    end
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      stat_q <= '0;
    end else if (wr_go && avs_address_in == ICLR_OFS && avs_byteenable_in[0]) begin
      stat_q <= (stat_q & ~avs_writedata_in[NEV-1:0]) | ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      irq_out      <= 1'b0;
      time_fmt_out <= 2'h0;
    end else begin
      irq_out      <= |((stat_q | ev) & ien_q);
      time_fmt_out <= flags_q[FMT_LSB +: 2];
    end
  end

  // ==========================================================
  // bit assembly
  logic [1:0]  mode;
  logic        a32;
  logic        framed;
  logic        fs;
  logic        take;
  logic [31:0] sh_q;
  logic [5:0]  cnt_q;
  logic [5:0]  last_bit;
  logic [1:0]  nhalf;
  logic [31:0] pend_q;
  logic [1:0]  halves_q;
  logic        aligned_q;
  logic        ld;
  logic [31:0] ld_val;

  assign mode     = ctrl_q[MODE_LSB +: 2];
  assign a32      = ctrl_q[ALIGN_BIT];
  assign framed   = (mode == MODE_PACK) || (mode == MODE_UNPK);
  assign fs       = framed & frame_first_in;
  assign last_bit = a32 ? 6'd31 : 6'd15;
  assign nhalf    = a32 ? 2'd2 : 2'd1;
  // until the first frame start of a packet, framed modes drop bits
  assign take     = ctrl_q[EN_BIT] & bit_valid_in & (~framed | aligned_q | fs);

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || pkt_start_in) begin
      aligned_q <= 1'b0;
    end else if (take && fs) begin
      aligned_q <= 1'b1;
    end
  end

  // a partial word left at a frame start goes out right-justified, zeros above
  assign ld     = take && ((fs && cnt_q != 6'd0) || (!fs && cnt_q == last_bit));
  assign ld_val = fs ? sh_q : {sh_q[30:0], bit_in};

  always_ff @(posedge ref_clk_in) begin
    if (rst_in || pkt_start_in) begin
      sh_q  <= 32'h0000_0000;
      cnt_q <= 6'd0;
    end else if (take) begin
      if (fs || cnt_q == last_bit) begin
        sh_q  <= fs ? {31'h0, bit_in} : 32'h0000_0000;
        cnt_q <= fs ? 6'd1 : 6'd0;
      end else begin
        sh_q  <= {sh_q[30:0], bit_in};
        cnt_q <= cnt_q + 6'd1;
      end
    end
  end

  // ==========================================================
  // output sequencer: pending data first, then channel word or frame header
  seq_state_t  st_q;
  logic [2:0]  idx_q;
  logic [63:0] tag_q;
  logic [15:0] dstat_q;
  logic        hdr_due_q;
  logic        csdw_due_q;
  logic        drain;
  logic [15:0] hdr_word;
  logic [2:0]  hdr_last;

  assign drain    = halves_q != 2'd0;
  assign hdr_last = a32 ? HDR_LAST32 : HDR_LAST16;

  always_comb begin
    unique case (idx_q)
      3'd0:    hdr_word = tag_q[15:0];
      3'd1:    hdr_word = tag_q[31:16];
      3'd2:    hdr_word = tag_q[47:32];
      3'd3:    hdr_word = tag_q[63:48];
      3'd4:    hdr_word = dstat_q;
      default: hdr_word = 16'h0000;
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pend_q   <= 32'h0000_0000;
      halves_q <= 2'd0;
    end else if (ld) begin
      pend_q   <= ld_val;
      halves_q <= nhalf;
    end else if (drain) begin
      pend_q   <= {16'h0000, pend_q[31:16]};
      halves_q <= halves_q - 2'd1;
    end
  end

  // time and lock state are held from the first bit until the header is out
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tag_q   <= 64'h0;
      dstat_q <= 16'h0000;
    end else if (take && fs && st_q != S_HDR && !hdr_due_q) begin
      tag_q <= flags_q[ABS_BIT] ? abs_time_in :
               {16'h0000, rtc_count_in};
      dstat_q <= {1'b1, sync_lock_in.minor_locked,
                  (sync_lock_in.major_code == 2'b01) ? 2'b00 :
                  sync_lock_in.major_code,
                  12'h000};
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      st_q       <= S_IDLE;
      idx_q      <= 3'd0;
      hdr_due_q  <= 1'b0;
      csdw_due_q <= 1'b0;
      word_out   <= '0;
    end else begin
      word_out.valid <= 1'b0;
      if (pkt_start_in) begin
        csdw_due_q <= 1'b1;
      end
      // no header is ever built in throughput mode, so no tag goes out there
      if (take && fs) begin
        hdr_due_q <= 1'b1;
      end
      if (drain) begin
        word_out <= '{valid: 1'b1, data: pend_q[15:0]};
      end else begin
        unique case (st_q)
          S_IDLE: begin
            if (csdw_due_q) begin
              st_q       <= S_CSDW;
              idx_q      <= 3'd0;
              csdw_due_q <= pkt_start_in;
            end else if (hdr_due_q) begin
              st_q      <= S_HDR;
              idx_q     <= 3'd0;
              hdr_due_q <= take && fs;
            end
          end
          S_CSDW: begin
            word_out <= '{valid: 1'b1,
                          data: idx_q[0] ? csdw_q[31:16] : csdw_q[15:0]};
            idx_q    <= idx_q + 3'd1;
            if (idx_q[0]) begin
              st_q <= S_IDLE;
            end
          end
          S_HDR: begin
            word_out <= '{valid: 1'b1, data: hdr_word};
            idx_q    <= idx_q + 3'd1;
            if (idx_q == hdr_last) begin
              st_q <= S_IDLE;
            end
          end
        endcase
      end
    end
  end

  // ==========================================================
  // events
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      fcnt_q <= 16'h0000;
    end else if (st_q == S_HDR && !drain && idx_q == hdr_last) begin
      fcnt_q <= fcnt_q + 16'h0001;
    end
  end

  always_comb begin
    ev          = '0;
    ev[EV_HDR]  = (st_q == S_HDR) && !drain && (idx_q == hdr_last);
    ev[EV_OVR]  = ld && (halves_q > 2'd1);
    ev[EV_CSDW] = (st_q == S_CSDW) && !drain && idx_q[0];
  end

endmodule : pcm_stream_packetizer

`default_nettype wire

//--- testbench.sv
// self-checking bench for the telemetry stream packetizer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pcm_pkt_pkg::*;
  // ==========
  logic             clk, rst, rd, wr, pst, go, bv, bt, ff, busy, wrq, irq;
  logic [4:0]       adr;
  logic [5:0]       len;
  logic [31:0]      wd, rdat, rv, pat;
  logic [47:0]      rtc, tag_rtc;
  logic [63:0]      abst, tag_abs;
  logic [1:0]       fmt;
  sync_lock_field_t lock;
  out_word_t        wo;
  logic [15:0]      wq[$];
  int               bad_count = 0, cmp_count = 0, cyc = 0;
  localparam logic [2:0]  LOCKS[3] = '{3'h7, 3'h2, 3'h1};
  localparam logic [15:0] STATS[3] = '{16'hF000, 16'hA000, 16'h8000};
  pcm_stream_packetizer i_dut (.ref_clk_in(clk), .rst_in(rst), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wrq), .pkt_start_in(pst),
    .bit_valid_in(bv), .bit_in(bt), .frame_first_in(ff), .sync_lock_in(lock),
    .rtc_count_in(rtc), .abs_time_in(abst), .word_out(wo), .time_fmt_out(fmt), .irq_out(irq));
  pcm_source i_src (.clk_in(clk), .rst_in(rst), .go_in(go), .len_in(len), .pat_in(pat),
    .bit_valid_out(bv), .bit_out(bt), .frame_first_out(ff), .busy_out(busy),
    .rtc_out(rtc), .abs_out(abst));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wo.valid === 1'b1) wq.push_back(wo.data);
    if (bv && ff) {tag_rtc, tag_abs} = {rtc, abst};
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end
  // ==========
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    {adr, wd, wr, rd} <= {a, d, w, !w};
    do @(posedge clk); while (wrq !== 1'b0);
    rv = rdat;
    {wr, rd} <= 2'b00;
  endtask : bus
  task rd_chk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rv, e);
  endtask : rd_chk
  task w16(input logic [15:0] e);
    for (int n = 0; n < 300 && wq.size() == 0; n++) @(posedge clk);
    if (wq.size() == 0) wq.push_back(~e);
    chk({16'h0, wq.pop_front()}, {16'h0, e});
  endtask : w16
  task frame(input logic [5:0] n, input logic [31:0] p);
    @(posedge clk);
    {len, pat, go} <= {n, p, 1'b1};
    @(posedge clk);
    go <= 1'b0;
    repeat (2 * n + 4) @(posedge clk);
  endtask : frame
  task pkt(input logic [3:0] c);
    bus(1'b1, CTRL_OFS, {28'h0, c});
    @(posedge clk);
    pst <= 1'b1;
    @(posedge clk);
    pst <= 1'b0;
    w16(16'h1234);
    w16(16'hABCD);
  endtask : pkt
  task results();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  // ==========
  initial begin
    {rd, wr, pst, go, adr, wd, len, pat, lock} = '0;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd_chk(CTRL_OFS, {28'h0, CTRL_RST});
    rd_chk(FLAGS_OFS, {24'h0, FLAGS_RST});
    rd_chk(CSDW_OFS, CSDW_RST);
    bus(1'b1, 5'h1C, 32'hFFFF_FFFF);
    rd_chk(5'h1C, 32'h0);
    $display("test registers done");
    bus(1'b1, CSDW_OFS, 32'hABCD_1234);
    pkt(4'h8);
    frame(6'd16, 32'hC3A5_0000);
    w16(16'hC3A5);
    pkt(4'hC);
    frame(6'd32, 32'h1234_5678);
    w16(16'h5678);
    w16(16'h1234);
    $display("test throughput done");
    bus(1'b1, IEN_OFS, 32'h1);
    pkt(4'h9);
    for (int i = 0; i < 3; i++) begin
      lock <= LOCKS[i];
      frame(6'd16, 32'hFACE_0000);
      for (int k = 0; k < 3; k++) w16(tag_rtc[16*k +: 16]);
      w16(16'h0000);
      w16(STATS[i]);
      w16(16'hFACE);
    end
    chk({31'h0, irq}, 32'h1);
    rd_chk(STAT_OFS, 32'h5);
    rd_chk(FCNT_OFS, 32'h3);
    bus(1'b1, ICLR_OFS, 32'h7);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd_chk(STAT_OFS, 32'h0);
    bus(1'b1, IEN_OFS, 32'h0);
    $display("test packed done");
    bus(1'b1, FLAGS_OFS, 32'h4C);
    repeat (2) @(posedge clk);
    chk({30'h0, fmt}, 32'h3);
    pkt(4'hE);
    frame(6'd32, 32'h1234_5678);
    for (int k = 0; k < 4; k++) w16(tag_abs[16*k +: 16]);
    w16(16'h8000);
    w16(16'h0000);
    w16(16'h5678);
    w16(16'h1234);
    rd_chk(STAT_OFS, 32'h5);
    chk({31'h0, irq}, 32'h0);
    $display("test unpacked done");
    results();
  end
endmodule : testbench
`default_nettype wire
